// >>> verilog/timer8_pkg.sv
// Overview of operation
// - non-PWM mode: writing force bit A applies an immediate compare event to output A
// - non-PWM mode: writing force bit B applies an immediate compare event to output B
// - forced compare sets no flag, no interrupt, no clear; force bits read zero
// - reserved bits of control B and mask register always read as zero
// - clock select: 0 stops, 1..5 give clock divided by 1, 8, 64, 256, 1024
// - clock select 6 counts falling, 7 counts rising edges of the count pin
// - count pin edges advance the counter even when the pin is an output
// - counter register gives direct read and write access to the count
// - writing the counter suppresses compare match on the following timer tick
// - compare A value is compared continuously; match flags or drives output A
// - compare B value is compared continuously; match flags or drives output B
// - mask bits 2,1,0 enable match B, match A, overflow; need flag and global bit
// - flag bit 2 sets when the counter matches compare B
// - flag bit 1 sets when the counter matches compare A
// - each flag clears when its interrupt vector is executed
// - writing one clears a flag, writing zero leaves it
// - flag bit 0 sets on overflow, at a count chosen by waveform mode
// - three-bit waveform mode picks sequence and top; PWM updates compare at top
// - overflow at 0xFF normal, CLEAR_ON_MATCH_MODE, fixed fast PWM; bottom phase-correct; top else
// - non-PWM action codes: 0 disconnect, 1 toggle, 2 clear, 3 set
package timer8_pkg;

    // ---------------------------------------------------------------
    // register map, byte addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_A    = 8'h00;
    localparam logic [7:0] OFS_CTRL_B    = 8'h04;
    localparam logic [7:0] OFS_COUNT     = 8'h08;
    localparam logic [7:0] OFS_CMP_A     = 8'h0C;
    localparam logic [7:0] OFS_CMP_B     = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;
    localparam logic [7:0] OFS_IRQ_FLAGS = 8'h18;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int FORCE_A_BIT   = 7;
    localparam int FORCE_B_BIT   = 6;
    localparam int WAVE_BIT2_POS = 3;
    localparam int CS_LSB        = 0;
    localparam int OUT_A_LSB     = 6;
    localparam int OUT_B_LSB     = 4;
    localparam int WAVE_LOW_LSB  = 0;
    localparam int IRQ_B_BIT     = 2;
    localparam int IRQ_A_BIT     = 1;
    localparam int IRQ_OVF_BIT   = 0;

    // writable masks, everything else reads zero
    localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
    localparam logic [3:0] CTRL_B_WMASK = 4'hF;
    localparam logic [2:0] IRQ_WMASK    = 3'h7;

    // ---------------------------------------------------------------
    // reset values and counter landmarks
    // ---------------------------------------------------------------
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_ONE    = 8'h01;
    localparam logic [9:0] PRESC_ONE  = 10'h001;

    // prescaler wrap masks for /8, /64, /256, /1024
    localparam logic [9:0] PRE_MASK_8    = 10'h007;
    localparam logic [9:0] PRE_MASK_64   = 10'h03F;
    localparam logic [9:0] PRE_MASK_256  = 10'h0FF;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;

    // clock select codes
    localparam logic [2:0] CS_STOP  = 3'h0;
    localparam logic [2:0] CS_DIV1  = 3'h1;
    localparam logic [2:0] CS_DIV8  = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256  = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // waveform modes
    localparam logic [2:0] WM_NORMAL   = 3'h0;
    localparam logic [2:0] WM_CTC      = 3'h2;
    localparam logic [2:0] WM_FAST_FF  = 3'h3;
    localparam logic [2:0] WM_PC_OCR   = 3'h5;
    localparam logic [2:0] WM_FAST_OCR = 3'h7;

    // output actions
    localparam logic [1:0] ACT_OFF    = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR  = 2'h2;
    localparam logic [1:0] ACT_SET    = 2'h3;

    typedef enum logic {DIR_UP, DIR_DOWN} dir_t;

    typedef struct packed {
        logic [7:0]  ctrl_a;
        logic [3:0]  ctrl_b;
        logic [7:0]  count;
        logic [7:0]  cmp_a;
        logic [7:0]  cmp_b;
        logic [7:0]  buf_a;
        logic [7:0]  buf_b;
        logic [2:0]  irq_en;
        logic [2:0]  flags;
        dir_t        dir;
        logic [9:0]  presc;
        logic        block;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_s3;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
        logic        wave_a;
        logic        wave_b;
        logic        en_a;
        logic        en_b;
        logic        irq_a;
        logic        irq_b;
        logic        irq_ovf;
    } state_t;

endpackage

// >>> verilog/timer8_control_and_flags.sv
`timescale 1ns/1ns
module timer8_control_and_flags
    import timer8_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_count_pin,
    input  wire logic        global_irq_en,
    input  wire logic        vector_ack_a,
    input  wire logic        vector_ack_b,
    input  wire logic        vector_ack_ovf,
    output logic             wave_out_a,
    output logic             wave_out_b,
    output logic             wave_en_a,
    output logic             wave_en_b,
    output logic             irq_match_a,
    output logic             irq_match_b,
    output logic             irq_overflow
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------

    // read mux; unmapped addresses read zero
    function automatic logic [7:0] read_byte(input logic [7:0] a, input state_t s);
        logic [7:0] v;
        v = RST_BYTE;
        case (a)
            OFS_CTRL_A:    v = s.ctrl_a & CTRL_A_WMASK;
            OFS_CTRL_B:    v = {4'h0, s.ctrl_b}; // force and reserved bits read zero
            OFS_COUNT:     v = s.count;
            OFS_CMP_A:     v = s.cmp_a;
            OFS_CMP_B:     v = s.cmp_b;
            OFS_IRQ_MASK:  v = {5'h00, s.irq_en & IRQ_WMASK};
            OFS_IRQ_FLAGS: v = {5'h00, s.flags};
            default:       v = RST_BYTE;
        endcase
        return v;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return (a == OFS_CTRL_A) || (a == OFS_CTRL_B) || (a == OFS_COUNT) ||
               (a == OFS_CMP_A) || (a == OFS_CMP_B) || (a == OFS_IRQ_MASK) ||
               (a == OFS_IRQ_FLAGS);
    endfunction

    // one output channel: next level for a hit or a top event
    function automatic logic wave_step(input logic cur, input logic [1:0] act,
                                       input logic hit, input logic at_top,
                                       input logic [2:0] mode, input dir_t dir,
                                       input logic tog_ok);
        logic v;
        v = cur;
        if (!mode[0])
        begin
            if (hit)
            begin
                case (act)
                    ACT_TOGGLE: v = ~cur;
                    ACT_CLEAR:  v = 1'b0;
                    ACT_SET:    v = 1'b1;
                    default:    v = cur;
                endcase
            end
        end
        else if (mode == WM_FAST_FF || mode == WM_FAST_OCR)
        begin
            case (act)
                ACT_TOGGLE: v = (hit && tog_ok) ? ~cur : cur;
                ACT_CLEAR:  v = at_top ? 1'b1 : (hit ? 1'b0 : cur);
                ACT_SET:    v = at_top ? 1'b0 : (hit ? 1'b1 : cur);
                default:    v = cur;
            endcase
        end
        else
        begin
            case (act)
                ACT_TOGGLE: v = (hit && tog_ok) ? ~cur : cur;
                ACT_CLEAR:  v = hit ? (dir == DIR_DOWN) : cur;
                ACT_SET:    v = hit ? (dir == DIR_UP) : cur;
                default:    v = cur;
            endcase
        end
        return v;
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    state_t r;
    state_t n;

    logic       tick;
    logic       match_a_c;
    logic       match_b_c;
    logic       ovf_c;
    logic       wr_acc;
    logic [2:0] mode;
    logic [2:0] cs;
    logic [7:0] act_a;
    logic [7:0] act_b;
    logic [7:0] top;
    logic       at_top;
    logic       force_a;
    logic       force_b;
    logic [2:0] clr;

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb
    begin
        n = r;
        cs = r.ctrl_b[CS_LSB +: 3];
        mode = {r.ctrl_b[WAVE_BIT2_POS], r.ctrl_a[WAVE_LOW_LSB +: 2]};
        wr_acc = psel && penable && pwrite && r.ready;
        // PWM modes compare against the buffered copy; others see writes at once
        act_a = mode[0] ? r.buf_a : r.cmp_a;
        act_b = mode[0] ? r.buf_b : r.cmp_b;
        top = (mode == WM_CTC || mode == WM_PC_OCR || mode == WM_FAST_OCR) ? act_a : CNT_MAX;
        at_top = (r.count == top);

        // pin sampled without regard to its direction; s1 only feeds s2
        n.ext_s1 = ext_count_pin;
        n.ext_s2 = r.ext_s1;
        n.ext_s3 = r.ext_s2;

        // prescaler only runs for internal divided sources
        n.presc = (cs >= CS_DIV1 && cs <= CS_DIV1024) ? r.presc + PRESC_ONE : '0;
        case (cs)
            CS_DIV1:     tick = 1'b1;
            CS_DIV8:     tick = (r.presc & PRE_MASK_8) == PRE_MASK_8;
            CS_DIV64:    tick = (r.presc & PRE_MASK_64) == PRE_MASK_64;
            CS_DIV256:   tick = (r.presc & PRE_MASK_256) == PRE_MASK_256;
            CS_DIV1024:  tick = (r.presc & PRE_MASK_1024) == PRE_MASK_1024;
            CS_EXT_FALL: tick = !r.ext_s2 && r.ext_s3;
            CS_EXT_RISE: tick = r.ext_s2 && !r.ext_s3;
            default:     tick = 1'b0;
        endcase

        // continuous compare, taken on the timer tick, muted after a count write
        match_a_c = tick && !r.block && (r.count == act_a);
        match_b_c = tick && !r.block && (r.count == act_b);
        ovf_c = 1'b0;

        // counting sequence
        if (tick)
        begin
            n.block = 1'b0;
            if (mode[1:0] == WM_PC_OCR[1:0]) // phase-correct with either top
            begin
                ovf_c = (r.count == CNT_BOTTOM) && (r.dir == DIR_DOWN);
                if (r.dir == DIR_UP)
                begin
                    n.dir = at_top ? DIR_DOWN : DIR_UP;
                    n.count = at_top ? r.count - CNT_ONE : r.count + CNT_ONE;
                end
                else
                begin
                    n.dir = (r.count == CNT_BOTTOM) ? DIR_UP : DIR_DOWN;
                    n.count = (r.count == CNT_BOTTOM) ? r.count + CNT_ONE
                                                      : r.count - CNT_ONE;
                end
            end
            else
            begin
                n.dir = DIR_UP;
                n.count = at_top ? CNT_BOTTOM : r.count + CNT_ONE;
                // overflow point depends on mode
                ovf_c = (mode == WM_FAST_OCR) ? at_top : (r.count == CNT_MAX);
            end
            // double buffer loads at top in PWM modes
            if (mode[0] && at_top)
            begin
                n.buf_a = r.cmp_a;
                n.buf_b = r.cmp_b;
            end
        end
        if (!mode[0])
        begin
            n.buf_a = r.cmp_a;
            n.buf_b = r.cmp_b;
        end

        // force strobes: non-PWM only, never stored, never flag or clear
        force_a = wr_acc && (paddr == OFS_CTRL_B) && pwdata[FORCE_A_BIT]
                  && !mode[0];
        force_b = wr_acc && (paddr == OFS_CTRL_B) && pwdata[FORCE_B_BIT]
                  && !mode[0];

        // waveform outputs; toggle in PWM only for A with mode bit 2 set
        n.wave_a = wave_step(r.wave_a, r.ctrl_a[OUT_A_LSB +: 2], match_a_c || force_a,
                             tick && at_top, mode, r.dir, mode[2]);
        n.wave_b = wave_step(r.wave_b, r.ctrl_a[OUT_B_LSB +: 2], match_b_c || force_b,
                             tick && at_top, mode, r.dir, 1'b0);
        n.en_a = (r.ctrl_a[OUT_A_LSB +: 2] != ACT_OFF);
        n.en_b = (r.ctrl_a[OUT_B_LSB +: 2] != ACT_OFF);

        // register writes; reserved positions are masked off
        clr = {vector_ack_b, vector_ack_a, vector_ack_ovf};
        if (wr_acc)
        begin
            case (paddr)
                OFS_CTRL_A:    n.ctrl_a = pwdata[7:0] & CTRL_A_WMASK;
                OFS_CTRL_B:    n.ctrl_b = pwdata[3:0] & CTRL_B_WMASK;
                OFS_COUNT:
                begin
                    n.count = pwdata[7:0];
                    n.block = 1'b1;
                end
                OFS_CMP_A:     n.cmp_a = pwdata[7:0];
                OFS_CMP_B:     n.cmp_b = pwdata[7:0];
                OFS_IRQ_MASK:  n.irq_en = pwdata[2:0] & IRQ_WMASK;
                OFS_IRQ_FLAGS: clr = clr | pwdata[2:0];
                default:       n.count = n.count;
            endcase
        end

        // hardware set wins over any clear in the same cycle
        n.flags = (r.flags & ~clr) | {match_b_c, match_a_c, ovf_c};

        // interrupt lines need enable, flag and global bit together
        n.irq_b = n.flags[IRQ_B_BIT] && n.irq_en[IRQ_B_BIT] && global_irq_en;
        n.irq_a = n.flags[IRQ_A_BIT] && n.irq_en[IRQ_A_BIT] && global_irq_en;
        n.irq_ovf = n.flags[IRQ_OVF_BIT] && n.irq_en[IRQ_OVF_BIT] && global_irq_en;

        // apb: data captured in setup, ready in first access cycle
        n.ready = psel && !penable;
        if (psel && !penable)
        begin
            n.rdata = {24'h000000, read_byte(paddr, r)};
            n.err = !mapped(paddr);
        end
    end

    // ---------------------------------------------------------------
    // state register; clk_en low freezes everything, bus included
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r <= '0;
        end
        else if (clk_en)
        begin
            r <= n;
        end
    end

    assign prdata = r.rdata;
    assign pready = r.ready;
    assign pslverr = r.err;
    assign wave_out_a = r.wave_a;
    assign wave_out_b = r.wave_b;
    assign wave_en_a = r.en_a;
    assign wave_en_b = r.en_b;
    assign irq_match_a = r.irq_a;
    assign irq_match_b = r.irq_b;
    assign irq_overflow = r.irq_ovf;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic wr_cb;
    logic wr_cnt;
    assign wr_cb = wr_acc && (paddr == OFS_CTRL_B);
    assign wr_cnt = wr_acc && (paddr == OFS_COUNT);

    a_force_a_toggle: assert property (
        (clk_en && wr_cb && pwdata[FORCE_A_BIT] && !mode[0] && !match_a_c &&
         r.ctrl_a[OUT_A_LSB +: 2] == ACT_TOGGLE) |=> (wave_out_a != $past(wave_out_a)))
        else $error("force A did not toggle output A");

    a_force_b_set: assert property (
        (clk_en && wr_cb && pwdata[FORCE_B_BIT] && !mode[0] &&
         r.ctrl_a[OUT_B_LSB +: 2] == ACT_SET) |=> wave_out_b)
        else $error("force B did not set output B");

    a_force_reads_zero: assert property (
        (clk_en && psel && !penable && paddr == OFS_CTRL_B) |=> (prdata[7:4] == 4'h0))
        else $error("force or reserved bits read nonzero");

    a_force_no_flag: assert property (
        (clk_en && wr_cb && pwdata[FORCE_A_BIT] && !match_a_c && !r.flags[IRQ_A_BIT])
        |=> !r.flags[IRQ_A_BIT])
        else $error("force strobe set a flag");

    a_stop_holds: assert property (
        (clk_en && cs == CS_STOP && !wr_cnt) |=> (r.count == $past(r.count)))
        else $error("stopped counter moved");

    a_div1_counts: assert property (
        (clk_en && cs == CS_DIV1 && mode == WM_NORMAL && !wr_cnt)
        |=> (r.count == $past(r.count) + CNT_ONE))
        else $error("undivided clock did not advance counter");

    a_ext_rise_count: assert property (
        (clk_en && cs == CS_EXT_RISE && mode == WM_NORMAL && !wr_cnt &&
         r.ext_s2 && !r.ext_s3) |=> (r.count == $past(r.count) + CNT_ONE))
        else $error("rising pin edge did not count");

    a_count_write: assert property (
        (clk_en && wr_cnt) |=> (r.count == $past(pwdata[7:0])))
        else $error("counter write lost");

    a_write_blocks: assert property (
        (clk_en && wr_cnt && pwdata[7:0] == r.cmp_a && r.count != r.cmp_a &&
         !r.flags[IRQ_A_BIT] && !mode[0]) ##1 (clk_en && !wr_acc)
        |=> !r.flags[IRQ_A_BIT])
        else $error("match not suppressed after counter write");

    a_set_wins: assert property (
        (clk_en && match_a_c) |=> r.flags[IRQ_A_BIT])
        else $error("match A flag not set");

    a_w1c_clear: assert property (
        (clk_en && wr_acc && paddr == OFS_IRQ_FLAGS && pwdata[IRQ_OVF_BIT] && !ovf_c)
        |=> !r.flags[IRQ_OVF_BIT])
        else $error("write one did not clear overflow flag");

    a_irq_gate: assert property (
        clk_en |=> (irq_match_b == (r.flags[IRQ_B_BIT] && r.irq_en[IRQ_B_BIT] &&
                                   $past(global_irq_en))))
        else $error("match B interrupt gating wrong");

    c_force: cover property (clk_en && force_a);
    c_overflow: cover property (clk_en && ovf_c ##1 irq_overflow);
    c_pc_turn: cover property (r.dir == DIR_UP ##1 r.dir == DIR_DOWN);

endmodule

// >>> verif/cpu_vector_model.sv
`timescale 1ns/1ns
// cpu side of the timer: runs the vector of a raised request, promptly or slowly
module cpu_vector_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       slow,
    input  wire logic [2:0] irq,
    output logic      [2:0] ack
);
    logic [3:0] dly_reg;

    // ----------------
    // vector entry
    // ----------------
    // lowest request wins; a late re-entry only clears an already clear flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack     <= 3'h0;
            dly_reg <= 4'h0;
        end
        else if (irq != 3'h0 && ack == 3'h0 && dly_reg >= (slow ? 4'h6 : 4'h0))
        begin
            ack     <= irq & (~irq + 3'h1);
            dly_reg <= 4'h0;
        end
        else
        begin
            ack     <= 3'h0;
            dly_reg <= (irq != 3'h0) ? dly_reg + 4'h1 : 4'h0;
        end
    end
endmodule

// >>> verif/timer8_control_and_flags_test.sv
`timescale 1ns/1ns
module timer8_control_and_flags_test;
    import timer8_pkg::*;
    typedef struct {
        logic [7:0] a;
        logic [7:0] lo;
        logic [7:0] hi;
        logic       e;
    } note_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        ext_count_pin, global_irq_en, slow;
    logic [7:0]  paddr, d;
    logic [31:0] pwdata, prdata;
    logic [2:0]  irq, ack;
    logic [1:0]  wave, wave_en, prev;
    note_t       cur;
    note_t       notes[$];
    int          fails, checks_done, n;
    int          div[5] = '{1, 8, 64, 256, 1024};
    logic [7:0]  ra[5] = '{OFS_COUNT, OFS_CMP_A, OFS_CMP_B, OFS_IRQ_MASK, OFS_CTRL_B};
    logic [7:0]  rm[5] = '{8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h08};

    timer8_control_and_flags i_timer8_control_and_flags (
        .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(ext_count_pin), .global_irq_en(global_irq_en),
        .vector_ack_a(ack[1]), .vector_ack_b(ack[2]), .vector_ack_ovf(ack[0]),
        .wave_out_a(wave[0]), .wave_out_b(wave[1]), .wave_en_a(wave_en[0]),
        .wave_en_b(wave_en[1]), .irq_match_a(irq[1]), .irq_match_b(irq[2]),
        .irq_overflow(irq[0]));
    cpu_vector_model i_cpu_vector_model (
        .pclk(pclk), .presetn(presetn), .slow(slow), .irq(irq), .ack(ack));

    // ----------------
    // shared tasks
    // ----------------
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic act_out(input logic [1:0] act, input logic p);
        return (act == ACT_TOGGLE) ? ~p : act[0];
    endfunction
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    // the request is held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, v};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1);
        cmp_bit("pready_wait", 1'b1, n == 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi,
                      input logic e);
        notes.push_back('{a, lo, hi, e});
        apb(1'b0, a, 8'h00);
    endtask
    task automatic print_verdict;
        if (fails == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // read monitor: oldest note against each completed read
    always @(posedge pclk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
            && notes.size() > 0)
        begin
            cur = notes.pop_front();
            checks_done++;
            if (pslverr !== cur.e || prdata[31:8] !== 24'h0 || (prdata[7:0] >= cur.lo) !== 1'b1
                || (prdata[7:0] <= cur.hi) !== 1'b1)
            begin
                fails++;
                $display("BAD read %h expected %h..%h err %b seen %h err %b", cur.a, cur.lo,
                         cur.hi, cur.e, prdata, pslverr);
            end
        end
    end

    // hang guard, well beyond the expected run of some 4600 cycles
    initial
    begin
        #300000;
        fails++;
        print_verdict();
    end

    // ----------------
    // scenarios
    // ----------------
    initial
    begin
        {presetn, psel, penable, pwrite, ext_count_pin} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        global_irq_en = 1'b1;
        void'($urandom(32'h249F));
        slow = 1'($urandom());
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            rd(8'(i * 4), 8'h00, 8'h00, 1'b0);
        rd(8'h1C, 8'h00, 8'h00, 1'b1);
        for (int i = 0; i < 15; i++)
        begin
            d = 8'($urandom());
            d = (i % 5 == 4) ? d & 8'hF8 : d;
            wr(ra[i % 5], d);
            rd(ra[i % 5], d & rm[i % 5], d & rm[i % 5], 1'b0);
        end
        wr(OFS_IRQ_MASK, 8'h00);
        // force strobes: every action code, twice, stopped counter
        for (int k = 0; k < 8; k++)
        begin
            wr(OFS_CTRL_A, {k[2:1], k[2:1], 4'h0});
            repeat (2) @(posedge pclk);
            prev = wave;
            wr(OFS_CTRL_B, 8'hC0);
            repeat (2) @(posedge pclk);
            cmp_bit("wave_en_a", k[2:1] != 2'h0, wave_en[0]);
            cmp_bit("wave_en_b", k[2:1] != 2'h0, wave_en[1]);
            if (k > 1) cmp_bit("wave_out_a", act_out(k[2:1], prev[0]), wave[0]);
            if (k > 1) cmp_bit("wave_out_b", act_out(k[2:1], prev[1]), wave[1]);
        end
        rd(OFS_IRQ_FLAGS, 8'h00, 8'h00, 1'b0);
        rd(OFS_CTRL_B, 8'h00, 8'h00, 1'b0);
        // a counter write masks the match on the very next tick only
        wr(OFS_CMP_A, 8'h20);
        wr(OFS_CMP_B, 8'h20);
        wr(OFS_COUNT, 8'h20);
        wr(OFS_CTRL_B, 8'(CS_DIV1));
        wr(OFS_CTRL_B, 8'(CS_STOP));
        rd(OFS_IRQ_FLAGS, 8'h00, 8'h00, 1'b0);
        wr(OFS_COUNT, 8'h1F);
        wr(OFS_CTRL_B, 8'(CS_DIV1));
        wr(OFS_CTRL_B, 8'(CS_STOP));
        rd(OFS_IRQ_FLAGS, 8'h06, 8'h06, 1'b0);
        // clears accumulate: nothing, then A, then B
        for (int k = 0; k < 3; k++)
        begin
            wr(OFS_IRQ_FLAGS, 8'(k * 2) & 8'h06);
            rd(OFS_IRQ_FLAGS, 8'h06 & ~8'(k * k + k), 8'h06 & ~8'(k * k + k), 1'b0);
        end
        // prescaled rates: three periods of each divider
        for (int c = 1; c < 6; c++)
        begin
            wr(OFS_COUNT, 8'h00);
            wr(OFS_CTRL_B, 8'(c));
            repeat (3 * div[c - 1]) @(posedge pclk);
            wr(OFS_CTRL_B, 8'(CS_STOP));
            rd(OFS_COUNT, (c == 1) ? 8'h03 : 8'h02, (c == 1) ? 8'h06 : 8'h04, 1'b0);
        end
        // count pin: three rising and two falling edges per run
        for (int c = 6; c < 8; c++)
        begin
            wr(OFS_COUNT, 8'h00);
            wr(OFS_CTRL_B, 8'(c));
            repeat (5)
            begin
                repeat (4) @(posedge pclk);
                ext_count_pin <= ~ext_count_pin;
            end
            repeat (6) @(posedge pclk);
            wr(OFS_CTRL_B, 8'(CS_STOP));
            rd(OFS_COUNT, 8'(c - 4), 8'(c - 4), 1'b0);
            ext_count_pin <= 1'b0;
        end
        // phase-correct pwm, top from compare A: turns at 0x20, overflows at bottom
        wr(OFS_CTRL_A, 8'hB1);
        wr(OFS_COUNT, 8'h1E);
        wr(OFS_CTRL_B, {4'h0, 1'b1, CS_DIV1});
        repeat (40) @(posedge pclk);
        wr(OFS_CTRL_B, 8'(CS_STOP));
        rd(OFS_COUNT, 8'h09, 8'h09, 1'b0);
        rd(OFS_IRQ_FLAGS, 8'h07, 8'h07, 1'b0);
        cmp_bit("wave_out_a", 1'b0, wave[0]);
        cmp_bit("wave_out_b", 1'b1, wave[1]);
        wr(OFS_CTRL_A, 8'h00);
        // enabling the match requests lets the cpu model run and clear both
        wr(OFS_IRQ_MASK, 8'h06);
        @(posedge pclk);
        cmp_bit("irq_match_a", 1'b1, irq[1]);
        cmp_bit("irq_match_b", 1'b1, irq[2]);
        repeat (20) @(posedge pclk);
        rd(OFS_IRQ_FLAGS, 8'h01, 8'h01, 1'b0);
        // overflow held back by the global bit, then serviced by the cpu model
        wr(OFS_IRQ_FLAGS, 8'h07);
        wr(OFS_IRQ_MASK, 8'h01);
        global_irq_en <= 1'b0;
        wr(OFS_COUNT, 8'hF8);
        wr(OFS_CTRL_B, 8'(CS_DIV1));
        repeat (20) @(posedge pclk);
        wr(OFS_CTRL_B, 8'(CS_STOP));
        cmp_bit("irq_overflow", 1'b0, irq[0]);
        rd(OFS_IRQ_FLAGS, 8'h01, 8'h01, 1'b0);
        global_irq_en <= 1'b1;
        repeat (2) @(posedge pclk);
        cmp_bit("irq_overflow", 1'b1, irq[0]);
        n = 0;
        while (irq[0] !== 1'b0 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        cmp_bit("irq_overflow", 1'b0, irq[0]);
        rd(OFS_IRQ_FLAGS, 8'h00, 8'h00, 1'b0);
        repeat (4) @(posedge pclk);
        print_verdict();
    end
endmodule
